// file: design/osc_pkg.sv
// Purpose: constants and types for the operand size control block
// Assumes: one microcycle clock, one microinstruction per valid cycle
// Notes: register offsets are byte addresses on the register bus
`default_nettype none
package osc_pkg;
  // ************************************************************
  // microinstruction kinds
  // ************************************************************
  typedef enum logic [2:0] {
    UI_BASIC, UI_MOVE, UI_EXTENDED, UI_MEMREQ,
    UI_DECODE, UI_MISC, UI_JUMP, UI_POP
  } osc_uinst_t;

  // ************************************************************
  // discrete register addresses and control fields
  // ************************************************************
  localparam logic [6:0] DISCRETE_BASE = 7'h7C;
  localparam logic [7:0] ADDR_SPECIFIER = 8'h7C;
  localparam logic [7:0] ADDR_SIZE_LOAD = 8'h7D;
  localparam logic [7:0] ADDR_SIZE_SWAP = 8'h7E;
  localparam int CW_FIELD_LO = 5;
  localparam logic [1:0] SEL_PREFETCH = 2'h1;
  localparam logic [3:0] DIAG_FUNC2 = 4'h4;

  // ************************************************************
  // size codes and derived controls
  // ************************************************************
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_UNUSED = 2'h2;
  localparam logic [1:0] SZ_LONG = 2'h3;
  localparam logic [1:0] CC_LONG_HOLD = 2'h0;
  localparam logic [1:0] CC_LONG_SET = 2'h1;
  localparam logic [1:0] CC_USE_SIZE = 2'h2;
  localparam logic [1:0] CC_COPY = 2'h3;
  localparam logic [1:0] MT_USE_SIZE = 2'h2;
  localparam logic [1:0] MCTL_BYTE = 2'h0;
  localparam logic [1:0] MCTL_WORD = 2'h1;
  localparam logic [1:0] MCTL_LONG = 2'h2;
  localparam logic [1:0] MCTL_HOLD = 2'h3;
  localparam logic [1:0] FLG_BYTE = 2'h0;
  localparam logic [1:0] FLG_WORD = 2'h1;
  localparam logic [1:0] FLG_LONG = 2'h2;
  localparam logic [1:0] FLG_HOLD = 2'h3;
  localparam int OPB_MSIZE_LO = 6;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int CTRL_COMPAT = 0;
  localparam int ST_SIZE_LO = 8;
  localparam int ST_MSIZE_LO = 10;
  localparam int ST_XFER_LO = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] RST_SPEC = 8'h00;
  localparam logic [1:0] RST_SIZE = 2'h0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage
`default_nettype wire

// file: design/osc_core.sv
// Purpose: operand specifier register and operand size control
// Assumes: control inputs come from logic on aclk, no synchronisers
// Notes: compatibility mode is set by software over AXI4-Lite
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`default_nettype none

// Functional notes
// - transfer write to address 7C loads specifier from result bits 7:0
// - specifier read puts it on bits 7:0, bit 7 copied into 31:8
// - dispatch loads specifier from prefetch byte per the input select
// - auxiliary op with function two of 4 drives specifier 3:0 on irq lines
// - dispatch loads size from first-operand code only in class decode phase
// - size codes 00 byte, 01 word, 11 longword; 10 unused
// - transfer write to 7D or 7E reloads size from result bits 1:0
// - address 7E reads current size onto operand bits 1:0 while loading
// - memory size never loads from result; reads on bits 7:6 with 7E
// - condition field 00 or 01 gives longword for ALU, transfer, extended
// - condition field 10 or 11 takes size register contents
// - compatibility mode turns any longword into word
// - memory request field 00, 01, 11 direct; 10 takes size register
// - transfer size code is presented on the memory controller bus
// - memory request sets load control 00, 01, 10 for byte, word, long
// - outside memory requests load control is 11, memory size holds
// - stored memory size steers read sign extension and width later
// - transfer size picks local store write width and flag set
// - byte enable for 00, plus word for 01, plus long for 11
// - flag load control 00, 01, 10 by size, 11 holds flags
module osc_core
  import osc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // microinstruction
  input wire logic uinst_valid,
  input wire osc_pkg::osc_uinst_t uinst_kind,
  input wire logic [31:0] control_word,
  input wire logic [7:0] dest_addr,
  input wire logic dp_write,
  input wire logic dp_read,
  input wire logic [3:0] misc_func2,
  // dispatch sources
  input wire logic [1:0] specifier_input_select,
  input wire logic [7:0] prefetch_buffer,
  input wire logic class_decode_phase,
  input wire logic [1:0] first_operand_size_code,
  // result and operand buses
  input wire logic [31:0] result_bus,
  output logic [31:0] operand_bus,
  // size controls
  output logic [1:0] memory_ctrl_bus,
  output logic [1:0] memory_size_load_ctl,
  output logic [1:0] memory_size_reg,
  output logic ls_en_byte,
  output logic ls_en_word,
  output logic ls_en_long,
  output logic flag_load_ctl_hi,
  output logic flag_load_ctl_lo,
  output logic [3:0] diag_irq,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0] spec;
    logic [1:0] size;
    logic [1:0] msize;
    logic [31:0] opbus;
    logic compat;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } osc_state_t;

  osc_state_t st_r;
  osc_state_t st_nxt;

  logic [1:0] cw_field;
  logic is_xfer;
  logic is_alu_group;
  logic is_memreq;
  logic discrete;
  logic [1:0] raw_size;
  logic [1:0] xfer_size;
  logic wr_go;
  logic rd_go;

  // ************************************************************
  // decode and transfer size
  // ************************************************************
  assign cw_field = control_word[CW_FIELD_LO +: 2];
  assign is_xfer = uinst_valid &&
                   (uinst_kind == UI_BASIC || uinst_kind == UI_MOVE);
  assign is_alu_group = is_xfer ||
                        (uinst_valid && uinst_kind == UI_EXTENDED);
  assign is_memreq = uinst_valid && uinst_kind == UI_MEMREQ;
  assign discrete = dest_addr[6:0] >= DISCRETE_BASE;

  always_comb begin
    raw_size = SZ_BYTE;
    if (is_alu_group) begin
      if (cw_field == CC_LONG_HOLD || cw_field == CC_LONG_SET) begin
        raw_size = SZ_LONG;
      end else begin
        raw_size = st_r.size;
      end
    end else if (is_memreq) begin
      if (cw_field == MT_USE_SIZE) begin
        raw_size = st_r.size;
      end else begin
        raw_size = cw_field;
      end
    end
  end

  // longword folds to word in compatibility mode
  assign xfer_size = (st_r.compat && raw_size == SZ_LONG) ?
                     SZ_WORD : raw_size;
  assign memory_ctrl_bus = xfer_size;

  // ************************************************************
  // local store enables and flag controls
  // ************************************************************
  always_comb begin
    ls_en_byte = 1'b0;
    ls_en_word = 1'b0;
    ls_en_long = 1'b0;
    if (is_xfer && dp_write && !discrete) begin
      ls_en_byte = 1'b1;
      ls_en_word = xfer_size == SZ_WORD || xfer_size == SZ_LONG;
      ls_en_long = xfer_size == SZ_LONG;
    end
  end

  always_comb begin
    logic [1:0] flg;
    flg = FLG_HOLD;
    if (is_alu_group && cw_field == CC_LONG_SET) begin
      flg = st_r.compat ? FLG_WORD : FLG_LONG;
    end else if (is_alu_group && cw_field == CC_USE_SIZE) begin
      case (xfer_size)
        SZ_BYTE: flg = FLG_BYTE;
        SZ_WORD: flg = FLG_WORD;
        SZ_LONG: flg = FLG_LONG;
        default: flg = FLG_HOLD;
      endcase
    end
    flag_load_ctl_hi = flg[1];
    flag_load_ctl_lo = flg[0];
  end

  // ************************************************************
  // memory size load control
  // ************************************************************
  always_comb begin
    memory_size_load_ctl = MCTL_HOLD;
    if (is_memreq) begin
      case (xfer_size)
        SZ_BYTE: memory_size_load_ctl = MCTL_BYTE;
        SZ_WORD: memory_size_load_ctl = MCTL_WORD;
        SZ_LONG: memory_size_load_ctl = MCTL_LONG;
        default: memory_size_load_ctl = MCTL_HOLD;
      endcase
    end
  end

  assign diag_irq = (uinst_valid && uinst_kind == UI_MISC &&
                     misc_func2 == DIAG_FUNC2) ? st_r.spec[3:0] : 4'h0;

  // ************************************************************
  // bus handshakes
  // ************************************************************
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !st_r.bvalid;
  assign rd_go = s_axi_arvalid && !st_r.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    // specifier register
    if (uinst_valid && uinst_kind == UI_DECODE &&
        specifier_input_select == SEL_PREFETCH) begin
      st_nxt.spec = prefetch_buffer;
    end else if (is_xfer && dp_write && dest_addr == ADDR_SPECIFIER) begin
      st_nxt.spec = result_bus[7:0];
    end
    // size register
    if (uinst_valid && uinst_kind == UI_DECODE && class_decode_phase) begin
      st_nxt.size = first_operand_size_code;
    end else if (is_xfer && dp_write && (dest_addr == ADDR_SIZE_LOAD ||
                 dest_addr == ADDR_SIZE_SWAP)) begin
      st_nxt.size = result_bus[1:0];
    end
    // memory size register, never from the result bus
    case (memory_size_load_ctl)
      MCTL_BYTE: st_nxt.msize = SZ_BYTE;
      MCTL_WORD: st_nxt.msize = SZ_WORD;
      MCTL_LONG: st_nxt.msize = SZ_LONG;
      default: st_nxt.msize = st_r.msize;
    endcase
    // operand bus, old contents shown on a swap
    if (is_xfer && dp_read && dest_addr == ADDR_SPECIFIER) begin
      st_nxt.opbus = {{24{st_r.spec[7]}}, st_r.spec};
    end else if (is_xfer && dp_read && dest_addr == ADDR_SIZE_SWAP) begin
      st_nxt.opbus = RST_WORD;
      st_nxt.opbus[1:0] = st_r.size;
      st_nxt.opbus[OPB_MSIZE_LO +: 2] = st_r.msize;
    end else begin
      st_nxt.opbus = RST_WORD;
    end
    // register writes
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      if (s_axi_awaddr == REG_CTRL) begin
        if (s_axi_wstrb[0]) begin
          st_nxt.compat = s_axi_wdata[CTRL_COMPAT];
        end
      end else if (s_axi_awaddr != REG_STATUS) begin
        st_nxt.bresp = RESP_SLVERR;
      end
    end
    // register reads
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (rd_go) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      st_nxt.rdata = RST_WORD;
      if (s_axi_araddr == REG_CTRL) begin
        st_nxt.rdata[CTRL_COMPAT] = st_r.compat;
      end else if (s_axi_araddr == REG_STATUS) begin
        st_nxt.rdata[7:0] = st_r.spec;
        st_nxt.rdata[ST_SIZE_LO +: 2] = st_r.size;
        st_nxt.rdata[ST_MSIZE_LO +: 2] = st_r.msize;
        st_nxt.rdata[ST_XFER_LO +: 2] = xfer_size;
      end else begin
        st_nxt.rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '{spec: RST_SPEC, size: RST_SIZE, msize: RST_SIZE,
                opbus: RST_WORD, compat: 1'b0, bvalid: 1'b0,
                bresp: RESP_OKAY, rvalid: 1'b0, rresp: RESP_OKAY,
                rdata: RST_WORD};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign operand_bus = st_r.opbus;
  assign memory_size_reg = st_r.msize;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_spec_write;
    is_xfer && dp_write && dest_addr == ADDR_SPECIFIER;
  endsequence
  property p_spec_load;
    s_spec_write |=> st_r.spec == $past(result_bus[7:0]);
  endproperty
  a_spec_load: assert property (p_spec_load)
    else $error("specifier not loaded from result bus");
  property p_sign_ext;
    (is_xfer && dp_read && dest_addr == ADDR_SPECIFIER) |=>
      operand_bus[31:8] == {24{operand_bus[7]}} &&
      operand_bus[7:0] == $past(st_r.spec);
  endproperty
  a_sign_ext: assert property (p_sign_ext)
    else $error("specifier read not sign extended");
  property p_diag;
    (uinst_valid && uinst_kind == UI_MISC && misc_func2 == DIAG_FUNC2)
      |-> diag_irq == st_r.spec[3:0];
  endproperty
  a_diag: assert property (p_diag)
    else $error("diagnostic irq lines wrong");
  property p_class_load;
    (uinst_valid && uinst_kind == UI_DECODE && class_decode_phase) |=>
      st_r.size == $past(first_operand_size_code);
  endproperty
  a_class_load: assert property (p_class_load)
    else $error("size not loaded at class decode");
  sequence s_swap;
    is_xfer && dp_read && dest_addr == ADDR_SIZE_SWAP;
  endsequence
  property p_swap_read;
    s_swap |=> operand_bus[1:0] == $past(st_r.size) &&
      operand_bus[OPB_MSIZE_LO +: 2] == $past(st_r.msize);
  endproperty
  a_swap_read: assert property (p_swap_read)
    else $error("size swap read wrong");
  property p_compat;
    st_r.compat |-> memory_ctrl_bus != SZ_LONG;
  endproperty
  a_compat: assert property (p_compat)
    else $error("longword in compatibility mode");
  property p_long_ctx;
    (is_alu_group && !st_r.compat && cw_field == CC_LONG_SET) |->
      memory_ctrl_bus == SZ_LONG && flag_load_ctl_hi && !flag_load_ctl_lo;
  endproperty
  a_long_ctx: assert property (p_long_ctx)
    else $error("longword context not produced");
  property p_mctl_hold;
    !is_memreq |-> memory_size_load_ctl == MCTL_HOLD ##1 $stable(st_r.msize);
  endproperty
  a_mctl_hold: assert property (p_mctl_hold)
    else $error("memory size changed outside request");
  property p_msize_load;
    (is_memreq && xfer_size == SZ_LONG) |->
      memory_size_load_ctl == MCTL_LONG ##1 memory_size_reg == SZ_LONG;
  endproperty
  a_msize_load: assert property (p_msize_load)
    else $error("memory size long not stored");
  property p_ls_width;
    ls_en_long |-> ls_en_word && ls_en_byte && xfer_size == SZ_LONG;
  endproperty
  a_ls_width: assert property (p_ls_width)
    else $error("local store enables inconsistent");

endmodule
`default_nettype wire

// file: sim/osc_memctl_model.sv
// Purpose: memory controller model that takes request sizes
// Assumes: a request is taken at the edge where a memory request executes
// Notes: keeps the last requested size and counts requests
`default_nettype none
module osc_memctl_model
  import osc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // request side
  input wire logic uinst_valid,
  input wire osc_pkg::osc_uinst_t uinst_kind,
  input wire logic [1:0] memory_ctrl_bus,
  // observed requests
  output logic [1:0] req_size,
  output logic [7:0] req_count
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_size <= SZ_BYTE;
      req_count <= 8'h00;
    end else if (uinst_valid && uinst_kind == UI_MEMREQ) begin
      req_size <= memory_ctrl_bus;
      req_count <= req_count + 8'h01;
    end
  end
endmodule
`default_nettype wire

// file: sim/operand_size_control_tb_top.sv
// Purpose: self-checking bench for the operand size control block
// Assumes: inputs change by non-blocking assignment on the rising edge
// Notes: operand bus reads are checked one cycle after the read
`default_nettype none
module operand_size_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import osc_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic aclk, aresetn, uinst_valid, dp_write, dp_read, class_decode_phase;
  osc_uinst_t uinst_kind;
  logic [31:0] control_word, result_bus, operand_bus;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [7:0] dest_addr, prefetch_buffer, s_axi_awaddr, s_axi_araddr;
  logic [7:0] req_count;
  logic [3:0] misc_func2, diag_irq, s_axi_wstrb;
  logic [1:0] specifier_input_select, first_operand_size_code;
  logic [1:0] memory_ctrl_bus, memory_size_load_ctl, memory_size_reg;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, req_size;
  logic ls_en_byte, ls_en_word, ls_en_long, flag_load_ctl_hi;
  logic flag_load_ctl_lo, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  int num_errors, checks_done;
  wire [3:0] axs = {s_axi_rvalid, s_axi_arready, s_axi_bvalid,
                    s_axi_awready & s_axi_wready};
  // ************************************************************
  // design and partner
  // ************************************************************
  osc_core osc_core_i (.aclk, .aresetn, .uinst_valid, .uinst_kind,
    .control_word, .dest_addr, .dp_write, .dp_read, .misc_func2,
    .specifier_input_select, .prefetch_buffer, .class_decode_phase,
    .first_operand_size_code, .result_bus, .operand_bus, .memory_ctrl_bus,
    .memory_size_load_ctl, .memory_size_reg, .ls_en_byte, .ls_en_word,
    .ls_en_long, .flag_load_ctl_hi, .flag_load_ctl_lo, .diag_irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  osc_memctl_model osc_memctl_model_i (.aclk, .aresetn, .uinst_valid,
    .uinst_kind, .memory_ctrl_bus, .req_size, .req_count);
  // ************************************************************
  // common tasks
  // ************************************************************
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic op(input osc_uinst_t k, input logic [1:0] f,
    input logic [7:0] d, input logic w, input logic r,
    input logic [31:0] y, input logic [3:0] f2 = 4'h0,
    input logic [1:0] sel = 2'h0, input logic ph = 1'b0);
    @(posedge aclk);
    uinst_valid <= 1'b1;
    uinst_kind <= k;
    control_word <= 32'(f) << CW_FIELD_LO;
    dest_addr <= d;
    dp_write <= w;
    dp_read <= r;
    result_bus <= y;
    misc_func2 <= f2;
    specifier_input_select <= sel;
    class_decode_phase <= ph;
    #1;
  endtask
  task automatic idle;
    @(posedge aclk);
    uinst_valid <= 1'b0;
    #1;
  endtask
  task automatic set_size(input logic [1:0] s);
    op(UI_MOVE, 2'h0, ADDR_SIZE_LOAD, 1'b1, 1'b0, {30'h0, s});
  endtask
  // wait for a handshake, take its answer before the edge
  task automatic hs(input int i);
    #1;
    while (axs[i] !== 1'b1) begin
      @(posedge aclk);
      #1;
    end
    rr = (i == 1) ? s_axi_bresp : s_axi_rresp;
    rd = s_axi_rdata;
    @(posedge aclk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hs(0);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    hs(1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hs(2);
    s_axi_arvalid <= 1'b0;
    hs(3);
    s_axi_rready <= 1'b0;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs;
    #1;
    chk(operand_bus, RST_WORD);
    chk(memory_size_reg, RST_SIZE);
    axi_rd(REG_CTRL);
    chk(rd, RST_WORD);
    chk(rr, RESP_OKAY);
    axi_rd(REG_STATUS);
    chk(rd, RST_WORD);
    axi_wr(REG_CTRL, 32'h1);
    axi_rd(REG_CTRL);
    chk(rd, 32'h1);
    axi_wr(REG_STATUS, 32'hFFFF_FFFF);
    chk(rr, RESP_OKAY);
    axi_rd(8'h08);
    chk(rr, RESP_SLVERR);
    chk(rd, RST_WORD);
    axi_wr(8'h0C, 32'h1);
    chk(rr, RESP_SLVERR);
    axi_wr(REG_CTRL, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_spec;
    op(UI_MOVE, 2'h0, ADDR_SPECIFIER, 1'b1, 1'b0, 32'h0000_0185);
    op(UI_BASIC, 2'h0, ADDR_SPECIFIER, 1'b0, 1'b1, 32'h0);
    op(UI_MISC, 2'h0, 8'h10, 1'b0, 1'b0, 32'h0, DIAG_FUNC2);
    chk(operand_bus, 32'hFFFF_FF85);
    chk(diag_irq, 4'h5);
    op(UI_MISC, 2'h0, 8'h10, 1'b0, 1'b0, 32'h0, 4'h3);
    chk(diag_irq, 4'h0);
    op(UI_DECODE, 2'h0, 8'h10, 1'b0, 1'b0, 32'h0, 4'h0, 2'h0);
    op(UI_BASIC, 2'h0, ADDR_SPECIFIER, 1'b0, 1'b1, 32'h0);
    op(UI_DECODE, 2'h0, 8'h10, 1'b0, 1'b0, 32'h0, 4'h0, SEL_PREFETCH);
    chk(operand_bus, 32'hFFFF_FF85);
    op(UI_BASIC, 2'h0, ADDR_SPECIFIER, 1'b0, 1'b1, 32'h0);
    idle;
    chk(operand_bus, 32'hFFFF_FFA6);
    $display("test specifier done");
  endtask
  task automatic t_size;
    op(UI_DECODE, 2'h0, 8'h10, 1'b0, 1'b0, 32'h0, 4'h0, 2'h0, 1'b0);
    op(UI_MOVE, 2'h0, ADDR_SIZE_SWAP, 1'b1, 1'b1, 32'h0000_00C3);
    idle;
    chk(operand_bus, 32'h0);
    chk(memory_size_reg, RST_SIZE);
    op(UI_DECODE, 2'h0, 8'h10, 1'b0, 1'b0, 32'h0, 4'h0, 2'h0, 1'b1);
    op(UI_BASIC, 2'h0, ADDR_SIZE_SWAP, 1'b0, 1'b1, 32'h0);
    idle;
    chk(operand_bus, 32'h1);
    set_size(SZ_LONG);
    op(UI_BASIC, 2'h0, ADDR_SIZE_SWAP, 1'b0, 1'b1, 32'h0);
    idle;
    chk(operand_bus, 32'h3);
    $display("test size done");
  endtask
  task automatic t_xfer;
    logic [1:0] x;
    logic [2:0] e;
    for (int m = 0; m < 2; m++) begin
      axi_wr(REG_CTRL, 32'(m));
      for (int s = 0; s < 4; s++) begin
        if (s == 2)
          continue;
        set_size(2'(s));
        for (int c = 0; c < 4; c++) begin
          op(s == 1 ? UI_MOVE : UI_BASIC, 2'(c), 8'h10, 1'b1, 1'b0, 32'h0);
          x = (c < 2) ? SZ_LONG : 2'(s);
          if (m == 1 && x == SZ_LONG)
            x = SZ_WORD;
          e = (x == SZ_BYTE) ? 3'h1 : (x == SZ_WORD) ? 3'h3 : 3'h7;
          chk(memory_ctrl_bus, x);
          chk({ls_en_long, ls_en_word, ls_en_byte}, e);
          if (c == 0 || c == 3)
            chk({flag_load_ctl_hi, flag_load_ctl_lo}, FLG_HOLD);
          else
            chk({flag_load_ctl_hi, flag_load_ctl_lo}, x == SZ_LONG ?
              FLG_LONG : x);
        end
      end
      op(UI_EXTENDED, 2'h1, 8'h10, 1'b0, 1'b0, 32'h0);
      chk(memory_ctrl_bus, m == 1 ? SZ_WORD : SZ_LONG);
    end
    $display("test transfer size done");
  endtask
  task automatic t_mem;
    logic [1:0] x;
    set_size(SZ_LONG);
    for (int m = 0; m < 2; m++) begin
      axi_wr(REG_CTRL, 32'(m));
      for (int f = 0; f < 4; f++) begin
        op(UI_MEMREQ, 2'(f), 8'h10, 1'b0, 1'b0, 32'h0);
        x = (f == 2) ? SZ_LONG : 2'(f);
        if (m == 1 && x == SZ_LONG)
          x = SZ_WORD;
        chk(memory_ctrl_bus, x);
        chk(memory_size_load_ctl, x == SZ_LONG ? MCTL_LONG : x);
        op(UI_BASIC, 2'h0, ADDR_SIZE_SWAP, 1'b0, 1'b1, 32'h0);
        chk(memory_size_load_ctl, MCTL_HOLD);
        chk(memory_size_reg, x);
        chk(req_size, x);
        idle;
        chk(operand_bus, {24'h0, x, 6'h3});
      end
    end
    chk(req_count, 8'h08);
    axi_rd(REG_STATUS);
    chk(rd & 32'h0FFF, 32'h07A6);
    axi_wr(REG_CTRL, 32'h0);
    $display("test memory request done");
  endtask
  // non-data kinds, and size code 10 left in the size register
  task automatic t_undef;
    op(UI_JUMP, 2'h3, 8'h10, 1'b1, 1'b0, 32'h0);
    chk(memory_ctrl_bus, SZ_BYTE);
    chk(memory_size_load_ctl, MCTL_HOLD);
    chk({ls_en_long, ls_en_word, ls_en_byte}, 3'h0);
    set_size(SZ_UNUSED);
    op(UI_BASIC, 2'h2, 8'h10, 1'b1, 1'b0, 32'h0);
    chk(memory_ctrl_bus, SZ_UNUSED);
    chk({ls_en_long, ls_en_word, ls_en_byte}, 3'h1);
    chk({flag_load_ctl_hi, flag_load_ctl_lo}, FLG_HOLD);
    op(UI_MEMREQ, 2'h2, 8'h10, 1'b0, 1'b0, 32'h0);
    chk(memory_size_load_ctl, MCTL_HOLD);
    idle;
    $display("test undefined size done");
  endtask
  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    {uinst_valid, dp_write, dp_read, class_decode_phase} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, aresetn} = '0;
    {control_word, result_bus, s_axi_wdata, dest_addr} = '0;
    {s_axi_awaddr, s_axi_araddr, misc_func2, specifier_input_select} = '0;
    uinst_kind = UI_BASIC;
    prefetch_buffer = 8'hA6;
    first_operand_size_code = SZ_WORD;
    s_axi_wstrb = 4'hF;
    num_errors = 0;
    checks_done = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_spec;
    t_size;
    t_xfer;
    t_mem;
    t_undef;
    summarize;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    summarize;
  end
endmodule
`default_nettype wire
